// file: pkg/mbdm_map.vh
// Purpose: constants for the request decoder and data mapper
// Assumes: included by bare name
// Notes:   function codes, limits, exception codes, buffer layout
`ifndef MBDM_MAP_VH
`define MBDM_MAP_VH

`define MBDM_FC_RD_COILS    8'h01
`define MBDM_FC_RD_DISC     8'h02
`define MBDM_FC_RD_HOLD     8'h03
`define MBDM_FC_RD_INREG    8'h04
`define MBDM_FC_WR_COIL     8'h05
`define MBDM_FC_WR_REG      8'h06
`define MBDM_FC_DIAG        8'h08
`define MBDM_FC_WR_COILS    8'h0F
`define MBDM_FC_WR_REGS     8'h10
`define MBDM_FC_MASK_WR     8'h16
`define MBDM_FC_RW_REGS     8'h17

`define MBDM_SUB_ECHO       16'h0000
`define MBDM_SUB_CLR        16'h000A
`define MBDM_SUB_CNT12      16'h000C
`define MBDM_SUB_CNT13      16'h000D
`define MBDM_SUB_CNT14      16'h000E

`define MBDM_MAX_BITS       16'h07D0
`define MBDM_MAX_RREGS      16'h007D
`define MBDM_MAX_WITEMS     16'h0320
`define MBDM_MAX_RW_WREGS   16'h0064

`define MBDM_REG_LAST       16'h04FF
`define MBDM_COIL_LAST      16'h4FFF
`define MBDM_REG_IN_LAST    16'h00FF
`define MBDM_REG_OUT_FIRST  16'h0400
`define MBDM_COIL_IN_LAST   16'h0FFF
`define MBDM_COIL_OUT_FIRST 16'h4000

`define MBDM_OUT_BASE       10'h200

`define MBDM_EXC_NONE       8'h00
`define MBDM_EXC_FUNC       8'h01
`define MBDM_EXC_ADDR       8'h02
`define MBDM_EXC_VALUE      8'h03

`endif

// file: verilog/mbdm_range_chk.v
// Purpose: checks that a zero-based span of items lies inside the mapped areas
// Assumes: first and count already validated for quantity, count >= 1
// Notes:   reserved gap between input and output areas is refused
`timescale 1ns/100ps
`default_nettype none
`include "mbdm_map.vh"

module mbdm_range_chk (
    input  wire        is_coil_i,
    input  wire        write_i,
    input  wire [15:0] first_i,
    input  wire [15:0] count_i,
    output wire        ok_o
);
    wire [16:0] last;
    wire [15:0] top;
    wire [15:0] in_last;
    wire [15:0] out_first;
    wire        in_area;
    wire        out_area;

    assign last      = {1'b0, first_i} + {1'b0, count_i} - 17'h00001;
    assign top       = is_coil_i ? `MBDM_COIL_LAST : `MBDM_REG_LAST;
    assign in_last   = is_coil_i ? `MBDM_COIL_IN_LAST : `MBDM_REG_IN_LAST;
    assign out_first = is_coil_i ? `MBDM_COIL_OUT_FIRST : `MBDM_REG_OUT_FIRST;
    // a span may not straddle the reserved gap
    assign in_area   = (last <= {1'b0, in_last}) && !write_i;
    assign out_area  = (first_i >= out_first) && (last <= {1'b0, top});
    assign ok_o      = in_area || out_area;
endmodule // mbdm_range_chk

`default_nettype wire

// file: verilog/mbdm_mapper.v
// Purpose: decodes a parsed request, validates it and moves data to and from the buffers
// Assumes: framing and CRC done outside; request fields arrive parsed on req_*
// Notes:   one request at a time; answer words stream out on rsp_*
`timescale 1ns/100ps
`default_nettype none
`include "mbdm_map.vh"

module mbdm_mapper #(
    parameter AW = 10
) (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        req_valid_i,
    input  wire [7:0]  req_func_i,
    input  wire [15:0] req_addr_i,
    input  wire [15:0] req_qty_i,
    input  wire [15:0] req_waddr_i,
    input  wire [15:0] req_wqty_i,
    input  wire [15:0] req_sub_i,
    output wire        req_ready_o,
    input  wire        wdat_valid_i,
    input  wire [15:0] wdat_i,
    output wire        wdat_ready_o,
    output wire        mem_we_o,
    output reg  [AW-1:0] mem_addr_o,
    output reg  [7:0]  mem_wdata_o,
    input  wire [7:0]  mem_rdata_i,
    output wire        rsp_valid_o,
    output reg  [15:0] rsp_data_o,
    output reg         rsp_last_o,
    output reg  [7:0]  rsp_exc_o,
    input  wire        rsp_ready_i
);
    localparam S_IDLE  = 6'b000001;
    localparam S_CHECK = 6'b000010;
    localparam S_WRITE = 6'b000100;
    localparam S_READ  = 6'b001000;
    localparam S_RSP   = 6'b010000;
    localparam S_WAIT  = 6'b100000;

    reg [5:0]  state;
    reg [7:0]  func;
    reg [15:0] addr;
    reg [15:0] qty;
    reg [15:0] waddr;
    reg [15:0] wqty;
    reg [15:0] sub;
    reg [15:0] idx;
    reg [15:0] word;
    reg [1:0]  phase;
    reg        wr_do;
    reg        rd_mem;

    // decode of the held request
    reg        fc_ok;
    reg        is_coil;
    reg        is_read;
    reg        is_write;
    reg        qty_ok;
    always @* begin
        fc_ok    = 1'b1;
        is_coil  = 1'b0;
        is_read  = 1'b0;
        is_write = 1'b0;
        qty_ok   = 1'b0;
        case (func)
            `MBDM_FC_RD_COILS, `MBDM_FC_RD_DISC: begin
                is_coil = 1'b1;
                is_read = 1'b1;
                qty_ok  = qty != 16'h0000 && qty <= `MBDM_MAX_BITS;
            end
            `MBDM_FC_RD_HOLD, `MBDM_FC_RD_INREG: begin
                is_read = 1'b1;
                qty_ok  = qty != 16'h0000 && qty <= `MBDM_MAX_RREGS;
            end
            `MBDM_FC_WR_COIL: begin
                is_coil  = 1'b1;
                is_write = 1'b1;
                qty_ok   = 1'b1;
            end
            `MBDM_FC_WR_REG, `MBDM_FC_MASK_WR: begin
                is_write = 1'b1;
                qty_ok   = 1'b1;
            end
            `MBDM_FC_WR_COILS: begin
                is_coil  = 1'b1;
                is_write = 1'b1;
                qty_ok   = qty != 16'h0000 && qty <= `MBDM_MAX_WITEMS;
            end
            `MBDM_FC_WR_REGS: begin
                is_write = 1'b1;
                qty_ok   = qty != 16'h0000 && qty <= `MBDM_MAX_WITEMS;
            end
            `MBDM_FC_RW_REGS: begin
                is_read  = 1'b1;
                is_write = 1'b1;
                qty_ok   = qty != 16'h0000 && qty <= `MBDM_MAX_RREGS
                        && wqty != 16'h0000 && wqty <= `MBDM_MAX_RW_WREGS;
            end
            `MBDM_FC_DIAG: begin
                qty_ok = sub == `MBDM_SUB_ECHO || sub == `MBDM_SUB_CLR
                      || sub == `MBDM_SUB_CNT12 || sub == `MBDM_SUB_CNT13
                      || sub == `MBDM_SUB_CNT14;
            end
            default: fc_ok = 1'b0;
        endcase
    end

    // single-item functions span one item at the write address
    wire        single = func == `MBDM_FC_WR_COIL || func == `MBDM_FC_WR_REG
                      || func == `MBDM_FC_MASK_WR;
    wire [15:0] w_first = (func == `MBDM_FC_RW_REGS) ? waddr : addr;
    wire [15:0] w_count = single ? 16'h0001 : ((func == `MBDM_FC_RW_REGS) ? wqty : qty);
    wire        rd_ok;
    wire        wr_ok;

    mbdm_range_chk u_rd_chk (
        .is_coil_i (is_coil),
        .write_i   (1'b0),
        .first_i   (addr),
        .count_i   (qty),
        .ok_o      (rd_ok)
    );

    mbdm_range_chk u_wr_chk (
        .is_coil_i (is_coil),
        .write_i   (1'b1),
        .first_i   (w_first),
        .count_i   (w_count),
        .ok_o      (wr_ok)
    );

    wire addr_ok = (!is_read || rd_ok) && (!is_write || wr_ok);

    // register number to byte location: inputs 0..255, outputs 1024..1279
    function [AW-1:0] reg_byte;
        input [15:0] r;
        input        lo;
        begin
            reg_byte = r[10] ? (`MBDM_OUT_BASE | {r[7:0], lo}) : {1'b0, r[7:0], lo};
        end
    endfunction

    // a register write walks its two bytes, high byte first, one write word each
    wire [15:0] w_bytes  = is_coil ? w_count : {w_count[14:0], 1'b0};
    wire [15:0] w_item   = w_first + (is_coil ? idx : {1'b0, idx[15:1]});
    // current item addressed by the walk
    wire [15:0] cur_item = (state == S_WRITE) ? w_item : (addr + idx);
    wire [15:0] cur_reg  = is_coil ? {4'h0, cur_item[15:4]} : cur_item;
    // coil n lies in bit 15-(n mod 16): bit 15..8 in the first byte
    wire [3:0]  cbit     = 4'hF - cur_item[3:0];
    wire        chi      = cbit[3];
    wire [2:0]  cpos     = cbit[2:0];
    wire        cvalue   = (func == `MBDM_FC_WR_COIL) ? (wdat_i == 16'hFF00) : wdat_i[idx[3:0]];

    assign req_ready_o  = state == S_IDLE;
    assign rsp_valid_o  = state == S_RSP;
    assign mem_we_o     = wr_do;
    assign wdat_ready_o = state == S_WRITE && phase == 2'b11;

    always @(posedge clock_i) begin
        if (rst_i) begin
            state       <= S_IDLE;
            func        <= 8'h00;
            addr        <= 16'h0000;
            qty         <= 16'h0000;
            waddr       <= 16'h0000;
            wqty        <= 16'h0000;
            sub         <= 16'h0000;
            idx         <= 16'h0000;
            word        <= 16'h0000;
            phase       <= 2'b00;
            wr_do       <= 1'b0;
            rd_mem      <= 1'b0;
            mem_addr_o  <= {AW{1'b0}};
            mem_wdata_o <= 8'h00;
            rsp_data_o  <= 16'h0000;
            rsp_last_o  <= 1'b0;
            rsp_exc_o   <= `MBDM_EXC_NONE;
        end else if (ce_i) begin
            wr_do <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (req_valid_i) begin
                        func  <= req_func_i;
                        addr  <= req_addr_i;
                        qty   <= req_qty_i;
                        waddr <= req_waddr_i;
                        wqty  <= req_wqty_i;
                        sub   <= req_sub_i;
                        idx   <= 16'h0000;
                        phase <= 2'b00;
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    rsp_last_o <= 1'b1;
                    rsp_data_o <= 16'h0000;
                    if (!fc_ok) begin
                        rsp_exc_o <= `MBDM_EXC_FUNC;
                        state     <= S_RSP;
                    end else if (!qty_ok) begin
                        rsp_exc_o <= `MBDM_EXC_VALUE;
                        state     <= S_RSP;
                    end else if (!addr_ok) begin
                        rsp_exc_o <= `MBDM_EXC_ADDR;
                        state     <= S_RSP;
                    end else begin
                        rsp_exc_o <= `MBDM_EXC_NONE;
                        rsp_data_o <= (func == `MBDM_FC_DIAG) ? sub : 16'h0000;
                        state     <= is_write ? S_WRITE : (is_read ? S_READ : S_RSP);
                    end
                end
                // per byte: phase 0 address, 1 settle, 2 latch old byte, 3 take data and write
                S_WRITE: begin
                    phase <= phase + 2'b01;
                    if (phase == 2'b00) begin
                        mem_addr_o <= reg_byte(cur_reg, is_coil ? !chi : idx[0]);
                    end else if (phase == 2'b10) begin
                        word[7:0] <= mem_rdata_i;
                    end else if (phase == 2'b11) begin
                        if (!wdat_valid_i) begin
                            phase <= 2'b11;
                        end else begin
                            wr_do <= 1'b1;
                            if (is_coil) begin
                                mem_wdata_o <= word[7:0];
                                mem_wdata_o[cpos] <= cvalue;
                            end else if (func == `MBDM_FC_MASK_WR) begin
                                // AND mask in the upper half of the word, OR mask in the lower
                                mem_wdata_o <= (word[7:0] & wdat_i[15:8])
                                             | (wdat_i[7:0] & ~wdat_i[15:8]);
                            end else begin
                                mem_wdata_o <= wdat_i[7:0];
                            end
                            idx <= idx + 16'h0001;
                            if (idx + 16'h0001 == w_bytes) begin
                                state <= is_read ? S_READ : S_RSP;
                                idx   <= 16'h0000;
                            end
                        end
                    end
                end
                // per item: set address, capture data, hand out
                S_READ: begin
                    if (!rd_mem) begin
                        mem_addr_o <= reg_byte(cur_reg, is_coil ? !chi : phase[0]);
                        rd_mem     <= 1'b1;
                    end else begin
                        rd_mem <= 1'b0;
                        if (is_coil) begin
                            rsp_data_o <= {15'h0000, mem_rdata_i[cpos]};
                            rsp_last_o <= idx + 16'h0001 == qty;
                            state      <= S_RSP;
                        end else if (phase[0] == 1'b0) begin
                            rsp_data_o[15:8] <= mem_rdata_i;
                            phase <= 2'b01;
                        end else begin
                            rsp_data_o[7:0] <= mem_rdata_i;
                            rsp_last_o      <= idx + 16'h0001 == qty;
                            phase <= 2'b00;
                            state <= S_RSP;
                        end
                    end
                end
                S_RSP: begin
                    if (rsp_ready_i) begin
                        if (rsp_last_o) begin
                            state <= S_WAIT;
                        end else begin
                            idx   <= idx + 16'h0001;
                            state <= S_READ;
                        end
                    end
                end
                S_WAIT: begin
                    state    <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // mbdm_mapper

`default_nettype wire

// file: bench/mbdm_mapper_sva.sv
// Purpose: port-level checker for the request decoder and data mapper
// Assumes: sees only the mapper ports, single clock domain
// Notes:   exception timing follows the take, check, answer walk
`timescale 1ns/100ps
`default_nettype none
module mbdm_mapper_sva #(
    parameter AW = 10
) (
    input wire logic          clock_i,
    input wire logic          rst_i,
    input wire logic          ce_i,
    input wire logic          req_valid_i,
    input wire logic [7:0]    req_func_i,
    input wire logic [15:0]   req_addr_i,
    input wire logic [15:0]   req_qty_i,
    input wire logic [15:0]   req_wqty_i,
    input wire logic [15:0]   req_sub_i,
    input wire logic          req_ready_o,
    input wire logic          mem_we_o,
    input wire logic [AW-1:0] mem_addr_o,
    input wire logic          rsp_valid_o,
    input wire logic [15:0]   rsp_data_o,
    input wire logic          rsp_last_o,
    input wire logic [7:0]    rsp_exc_o,
    input wire logic          rsp_ready_i
);
    logic take;
    logic fc_ok;
    assign take  = req_valid_i && req_ready_o && ce_i;
    assign fc_ok = req_func_i inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                                      8'h0F, 8'h10, 8'h16, 8'h17};
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_ready_after_reset: assert property ($fell(rst_i) |-> req_ready_o)
        else $error("decoder not ready after reset");
    a_busy_refuses: assert property (take |=> !req_ready_o)
        else $error("ready while a request is in work");
    a_bad_func_exc: assert property (take && !fc_ok |-> ##2 rsp_valid_o && rsp_last_o && rsp_exc_o == 8'h01)
        else $error("unsupported function not answered with code 1");
    a_no_write_exc: assert property (take && !fc_ok |=> (!mem_we_o) [*3])
        else $error("buffer written on unsupported function");
    a_read_qty_exc: assert property (take && req_func_i == 8'h03 && (req_qty_i == 16'h0000 || req_qty_i > 16'h007D) |-> ##2 rsp_valid_o && rsp_exc_o == 8'h03)
        else $error("bad register read count not refused");
    a_rw_limit_exc: assert property (take && req_func_i == 8'h17 && (req_wqty_i == 16'h0000 || req_wqty_i > 16'h0064) |-> ##2 rsp_valid_o && rsp_exc_o == 8'h03)
        else $error("combined write count not refused");
    a_diag_sub_exc: assert property (take && req_func_i == 8'h08 && !(req_sub_i inside {16'h0000, 16'h000A, 16'h000C, 16'h000D, 16'h000E}) |-> ##2 rsp_valid_o && rsp_exc_o == 8'h03)
        else $error("unsupported diagnostics subfunction not refused");
    a_reserved_addr: assert property (take && req_func_i == 8'h03 && req_qty_i == 16'h0001 && req_addr_i inside {[16'h0100:16'h03FF]} |-> ##2 rsp_valid_o && rsp_exc_o == 8'h02)
        else $error("reserved register not refused");
    a_write_out_only: assert property (mem_we_o |-> mem_addr_o[AW-1])
        else $error("write reached the input buffer");
    a_rsp_stands: assert property (rsp_valid_o && !rsp_ready_i && ce_i |=> rsp_valid_o && $stable(rsp_data_o) && $stable(rsp_last_o))
        else $error("answer word changed before it was taken");

    c_exception: cover property (take ##2 rsp_exc_o == 8'h02);
    c_write: cover property (mem_we_o);
    c_stall: cover property (rsp_valid_o && !rsp_ready_i);
endmodule // mbdm_mapper_sva
`default_nettype wire

// file: bench/mbdm_buf_model.sv
// Purpose: shared buffer memory standing behind the mapper
// Assumes: reads are combinational, writes land on the clock edge
// Notes:   input half 0x000-0x1FF, output half 0x200-0x3FF
`timescale 1ns/100ps
`default_nettype none
module mbdm_buf_model (
    input wire logic       clock_i,
    input wire logic       we_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic     [7:0] rdata_o
);
    logic [7:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
    end
    assign rdata_o = mem[addr_i];
    // no guard on the write side, so a stray input-half write shows up in the bench
    always @(posedge clock_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
    end
endmodule // mbdm_buf_model
`default_nettype wire

// file: bench/mbdm_mapper_test.sv
// Purpose: self-checking bench for the request decoder and data mapper
// Assumes: clock enable held high, write part of combined requests at 0x0400 unless moved
// Notes:   each scenario drives requests and judges the answers itself
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mbdm_mapper_test;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req_valid_i = 1'b0, wdat_valid_i = 1'b0, rsp_ready_i = 1'b0;
    logic [7:0]  req_func_i = 8'h00, got_exc, mem_wdata_o, mem_rdata_i, rsp_exc_o;
    logic [15:0] req_addr_i = 16'h0000, req_qty_i = 16'h0000, req_wqty_i = 16'h0000;
    logic [15:0] req_sub_i = 16'h0000, wdat_i = 16'h0000, got_data, rsp_data_o;
    logic [15:0] req_waddr_i = 16'h0400;
    logic        req_ready_o, wdat_ready_o, mem_we_o, rsp_valid_o, rsp_last_o, got_last;
    logic [9:0]  mem_addr_o;
    int          err_count = 0, samples_checked = 0;
    always #12.5 clock_i = ~clock_i;

    mbdm_mapper #(.AW(10)) mbdm_mapper_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
        .req_valid_i(req_valid_i), .req_func_i(req_func_i), .req_addr_i(req_addr_i),
        .req_qty_i(req_qty_i), .req_waddr_i(req_waddr_i), .req_wqty_i(req_wqty_i),
        .req_sub_i(req_sub_i), .req_ready_o(req_ready_o), .wdat_valid_i(wdat_valid_i),
        .wdat_i(wdat_i), .wdat_ready_o(wdat_ready_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_last_o(rsp_last_o),
        .rsp_exc_o(rsp_exc_o), .rsp_ready_i(rsp_ready_i));
    mbdm_buf_model mbdm_buf_model_inst (.clock_i(clock_i), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one request with up to two write words; first answer word kept, first word stalled once
    task automatic xfer(input logic [7:0] fc, input logic [15:0] a, q, wq, sb, w0, w1,
                        input int nw);
        int n;
        int k;
        int words;
        n = 0;
        k = 0;
        words = 0;
        got_last = 1'b0;
        @(posedge clock_i);
        req_func_i <= fc;
        req_addr_i <= a;
        req_qty_i <= q;
        req_wqty_i <= wq;
        req_sub_i <= sb;
        req_valid_i <= 1'b1;
        wdat_i <= w0;
        wdat_valid_i <= (nw > 0);
        while (!got_last && n < 10000) begin
            @(posedge clock_i);
            n++;
            if (req_valid_i && req_ready_o) req_valid_i <= 1'b0;
            if (wdat_valid_i && wdat_ready_o) begin
                k++;
                wdat_i <= w1;
                wdat_valid_i <= (k < nw);
            end
            if (rsp_valid_o && !rsp_ready_i) rsp_ready_i <= 1'b1;
            if (rsp_valid_o && rsp_ready_i) begin
                if (words == 0) begin
                    got_data = rsp_data_o;
                    got_exc = rsp_exc_o;
                end
                words++;
                got_last = rsp_last_o;
                rsp_ready_i <= !rsp_last_o;
            end
        end
        `CHK(got_last, 1'b1)
        @(posedge clock_i);
        wdat_valid_i <= 1'b0;
    endtask

    task automatic t_table;
        logic [63:0] tb [23] = '{
            64'h0000000001000001, 64'h0700000001000001, 64'h0900000001000001,
            64'h1100000001000001, 64'h1800000001000001, 64'h01000007D1000003,
            64'h0200000000000003, 64'h030000007E000003, 64'h0400000000000003,
            64'h0F40000321000003, 64'h1004000321000003, 64'h1700000001006503,
            64'h170000007E000103, 64'h0301000001000002, 64'h0300FF0002000002,
            64'h0304FF0002000002, 64'h0110000001000002, 64'h014FFF0002000002,
            64'h0550000001000002, 64'h0600000001000002, 64'h0F00000010000002,
            64'h0304FF0001000000, 64'h014FFF0001000000};
        mbdm_buf_model_inst.mem[0] = 8'h11;
        foreach (tb[i]) begin
            xfer(tb[i][63:56], tb[i][55:40], tb[i][39:24], tb[i][23:8], 16'h0000,
                 16'h0000, 16'h0000, 0);
            `CHK(got_exc, tb[i][7:0])
        end
        `CHK(mbdm_buf_model_inst.mem[0], 8'h11)
    endtask

    task automatic t_diag;
        logic [15:0] sb [8] = '{16'h0000, 16'h000A, 16'h000C, 16'h000D, 16'h000E,
                                16'h0001, 16'h000B, 16'h000F};
        foreach (sb[i]) begin
            xfer(8'h08, 16'h0000, 16'h0000, 16'h0000, sb[i], 16'h0000, 16'h0000, 0);
            `CHK(got_exc, (i < 5) ? 8'h00 : 8'h03)
            if (i < 5) `CHK(got_data, sb[i])
        end
    endtask

    task automatic t_read;
        mbdm_buf_model_inst.mem[10'h1FE] = 8'h12;
        mbdm_buf_model_inst.mem[10'h1FF] = 8'h34;
        mbdm_buf_model_inst.mem[10'h3FE] = 8'h56;
        mbdm_buf_model_inst.mem[10'h3FF] = 8'h78;
        xfer(8'h04, 16'h00FF, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_data, 16'h1234)
        xfer(8'h03, 16'h04FF, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_data, 16'h5678)
        xfer(8'h03, 16'h0000, 16'h007D, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_exc, 8'h00)
        mbdm_buf_model_inst.mem[0] = 8'h80;
        xfer(8'h01, 16'h0000, 16'h07D0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_exc, 8'h00)
        `CHK(got_data, 16'h0001)
        xfer(8'h17, 16'h00FF, 16'h0001, 16'h0001, 16'h0000, 16'h0099, 16'h0088, 2);
        `CHK(got_data, 16'h1234)
        `CHK(mbdm_buf_model_inst.mem[10'h200], 8'h99)
        req_waddr_i <= 16'h00FF;
        xfer(8'h17, 16'h00FF, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_exc, 8'h02)
        req_waddr_i <= 16'h0400;
    endtask

    task automatic t_write;
        xfer(8'h06, 16'h0400, 16'h0001, 16'h0000, 16'h0000, 16'h00AB, 16'h00CD, 2);
        `CHK({mbdm_buf_model_inst.mem[10'h200], mbdm_buf_model_inst.mem[10'h201]}, 16'hABCD)
        xfer(8'h03, 16'h0400, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 0);
        `CHK(got_data, 16'hABCD)
        xfer(8'h16, 16'h0400, 16'h0001, 16'h0000, 16'h0000, 16'hF005, 16'h0F30, 2);
        `CHK({mbdm_buf_model_inst.mem[10'h200], mbdm_buf_model_inst.mem[10'h201]}, 16'hA53D)
        mbdm_buf_model_inst.mem[10'h204] = 8'h00;
        xfer(8'h05, 16'h4020, 16'h0001, 16'h0000, 16'h0000, 16'hFF00, 16'h0000, 1);
        `CHK(mbdm_buf_model_inst.mem[10'h204], 8'h80)
    endtask

    initial begin
        #2000000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        t_table();
        t_diag();
        t_read();
        t_write();
        end_sim();
    end
endmodule // mbdm_mapper_test

bind mbdm_mapper mbdm_mapper_sva #(.AW(AW)) mbdm_mapper_sva_inst (.clock_i(clock_i),
    .rst_i(rst_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_func_i(req_func_i),
    .req_addr_i(req_addr_i), .req_qty_i(req_qty_i), .req_wqty_i(req_wqty_i),
    .req_sub_i(req_sub_i), .req_ready_o(req_ready_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_last_o(rsp_last_o), .rsp_exc_o(rsp_exc_o), .rsp_ready_i(rsp_ready_i));
`default_nettype wire
